// [rtl/scs_pkg.sv]
// Package: register map, field positions and reset values for the slow clock source select block
package scs_pkg;
   localparam logic [7:0] SCS_OFF_CLK_EN = 8'h08;
   localparam logic [7:0] SCS_OFF_PIN_DOM = 8'h18;
   localparam int SCS_BIT_XSEL = 0;
   localparam int SCS_BIT_EXT_EN = 1;
   localparam int SCS_BIT_INT_EN = 2;
   localparam int SCS_BIT_EMUL = 3;
   localparam int SCS_BIT_SW_DIS = 4;
   localparam int SCS_BIT_REF_SEL = 5;
   localparam int SCS_CLK_EN_W = 6;
   localparam logic [5:0] SCS_CLK_EN_RST = 6'h00;
   localparam logic [5:0] SCS_CLK_EN_BOOT = 6'h04;
   localparam int SCS_BIT_BGO_DOM = 1;
   localparam int SCS_BIT_BCO_DOM = 0;
   localparam logic [1:0] SCS_PIN_DOM_RST = 2'h3;
   typedef enum logic [2:0] {
      SCS_SRC_OFF = 3'b000,
      SCS_SRC_INT = 3'b001,
      SCS_SRC_XTAL = 3'b010,
      SCS_SRC_SE = 3'b011,
      SCS_SRC_SW = 3'b100
   } scs_src_t;
endpackage : scs_pkg

// [rtl/scs_top.sv]
// Slow clock source select and pin power-domain select with APB registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module scs_top
   import scs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_exception,
   input wire logic main_power_rail,
   input wire logic ext_clock_good,
   input wire logic int_osc_clk,
   input wire logic crystal_clk,
   input wire logic crystal_output_pin,
   input wire logic gpio_general_output,
   input wire logic battery_general_output,
   input wire logic battery_control_output,
   output logic slow_clk,
   output logic slow_clk_enabled,
   output logic int_osc_run,
   output logic crystal_osc_run,
   output logic ref_sel_switched,
   output logic [2:0] clk_source,
   output logic bgo_pin_out,
   output logic bgo_pin_oe,
   output logic bco_pin_out,
   output logic bco_pin_oe
);
   logic [5:0] clk_en_ff;
   logic [1:0] pin_dom_ff;
   logic [2:0] rail_sync_ff;
   logic [2:0] good_sync_ff;
   logic rail_on_ff;
   logic good_ff;
   logic [2:0] boot_sync_ff;
   logic boot_ff;
   logic [31:0] nxt_prdata;
   scs_src_t src;
   logic xsel, ext_en, int_en, emul, sw_dis;
   logic wr_acc, rd_acc, hit_clk, hit_pin;
   logic int_gate;

   assign xsel = clk_en_ff[SCS_BIT_XSEL];
   assign ext_en = clk_en_ff[SCS_BIT_EXT_EN];
   assign int_en = clk_en_ff[SCS_BIT_INT_EN];
   assign emul = clk_en_ff[SCS_BIT_EMUL];
   assign sw_dis = clk_en_ff[SCS_BIT_SW_DIS];

   assign hit_clk = (paddr == SCS_OFF_CLK_EN);
   assign hit_pin = (paddr == SCS_OFF_PIN_DOM);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_clk || hit_pin);

   // Async inputs pass three stages; a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rail_sync_ff <= 3'h0;
         good_sync_ff <= 3'h0;
         boot_sync_ff <= 3'h0;
         rail_on_ff <= 1'b0;
         good_ff <= 1'b0;
         boot_ff <= 1'b0;
      end else begin
         rail_sync_ff <= {rail_sync_ff[1:0], main_power_rail};
         good_sync_ff <= {good_sync_ff[1:0], ext_clock_good};
         boot_sync_ff <= {boot_sync_ff[1:0], boot_exception};
         if (rail_sync_ff[1] == rail_sync_ff[2]) rail_on_ff <= rail_sync_ff[2];
         if (good_sync_ff[1] == good_sync_ff[2]) good_ff <= good_sync_ff[2];
         if (boot_sync_ff[1] == boot_sync_ff[2]) boot_ff <= boot_sync_ff[2];
      end
   end

   // Boot rewrite has priority over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en_ff <= SCS_CLK_EN_RST;
      end else if (boot_ff) begin
         clk_en_ff <= SCS_CLK_EN_BOOT;
      end else if (wr_acc && hit_clk) begin
         clk_en_ff <= pwdata[SCS_CLK_EN_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_dom_ff <= SCS_PIN_DOM_RST;
      end else if (wr_acc && hit_pin) begin
         pin_dom_ff <= pwdata[1:0];
      end
   end

   always_comb begin
      nxt_prdata = 32'h0;
      if (hit_clk) nxt_prdata[SCS_CLK_EN_W-1:0] = clk_en_ff;
      if (hit_pin) nxt_prdata[1:0] = pin_dom_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (rd_acc) prdata <= nxt_prdata;
   end

   // Source selection table
   always_comb begin
      src = SCS_SRC_OFF;
      if (ext_en && !xsel) src = SCS_SRC_XTAL;
      else if (ext_en && xsel && (!int_en || sw_dis)) src = SCS_SRC_SE;
      else if (ext_en && xsel) src = SCS_SRC_SW;
      else if (int_en) src = SCS_SRC_INT;
   end

   // Internal clock survives rail-off only while battery emulation (emul) is clear
   assign int_gate = rail_on_ff || !emul;

   always_comb begin
      case (src)
         SCS_SRC_INT: begin
            slow_clk = int_osc_clk && int_gate;
            slow_clk_enabled = int_gate;
         end
         SCS_SRC_XTAL: begin
            slow_clk = crystal_clk;
            slow_clk_enabled = 1'b1;
         end
         SCS_SRC_SE: begin
            slow_clk = crystal_output_pin;
            slow_clk_enabled = 1'b1;
         end
         SCS_SRC_SW: begin
            // Switching only acts while the rail is on; fall back on a dead external clock
            if (rail_on_ff && good_ff) begin
               slow_clk = crystal_output_pin;
               slow_clk_enabled = 1'b1;
            end else begin
               slow_clk = int_osc_clk && int_gate;
               slow_clk_enabled = int_gate;
            end
         end
         default: begin
            slow_clk = 1'b0;
            slow_clk_enabled = 1'b0;
         end
      endcase
   end

   assign clk_source = src;
   assign int_osc_run = int_en && int_gate;
   assign crystal_osc_run = ext_en && !xsel;
   assign ref_sel_switched = clk_en_ff[SCS_BIT_REF_SEL];

   // Pin power domains; main-rail mode tristates the pin while the rail is down
   assign bgo_pin_out = pin_dom_ff[SCS_BIT_BGO_DOM] ? battery_general_output
                                                    : gpio_general_output;
   assign bgo_pin_oe = pin_dom_ff[SCS_BIT_BGO_DOM] || rail_on_ff;
   assign bco_pin_out = pin_dom_ff[SCS_BIT_BCO_DOM] ? battery_control_output
                                                    : gpio_general_output;
   assign bco_pin_oe = pin_dom_ff[SCS_BIT_BCO_DOM] || rail_on_ff;

   // Assertions
   // Filtered inputs act on the fourth sampled edge, so the input sequences span four cycles
   sequence boot_held_s;
      boot_exception [*4];
   endsequence
   sequence boot_forced_s;
      boot_ff ##1 (clk_en_ff == SCS_CLK_EN_BOOT);
   endsequence
   sequence rail_up_s;
      main_power_rail [*4];
   endsequence
   sequence rail_down_s;
      (!main_power_rail) [*4];
   endsequence
   sequence good_up_s;
      ext_clock_good [*4];
   endsequence
   sequence clk_wr_s;
      wr_acc && hit_clk && !boot_ff;
   endsequence
   sequence pin_wr_s;
      wr_acc && hit_pin;
   endsequence

   reset_vals_a: assert property (@(posedge pclk)
      $rose(presetn) |->
      (clk_en_ff == SCS_CLK_EN_RST && pin_dom_ff == SCS_PIN_DOM_RST))
      else $error("reset values wrong");
   both_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ext_en && !int_en) |->
      (!slow_clk_enabled && !slow_clk))
      else $error("clock not disabled");
   boot_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      boot_ff |=>
      clk_en_ff == SCS_CLK_EN_BOOT)
      else $error("boot rewrite missing");
   boot_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
      boot_held_s |=>
      boot_forced_s)
      else $error("boot request not applied");
   xtal_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ext_en && !xsel) |->
      (src == SCS_SRC_XTAL && slow_clk == crystal_clk))
      else $error("crystal not selected");
   se_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ext_en && xsel && (!int_en || sw_dis)) |->
      slow_clk == crystal_output_pin)
      else $error("single ended not selected");
   int_emul_a: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SCS_SRC_INT && !rail_on_ff) |->
      slow_clk_enabled == !emul)
      else $error("emulation gating wrong");
   int_batt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SCS_SRC_INT && !emul) |->
      slow_clk == int_osc_clk)
      else $error("internal clock lost");
   sw_primary_a: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SCS_SRC_SW && rail_on_ff && good_ff) |->
      (slow_clk == crystal_output_pin && slow_clk_enabled))
      else $error("primary clock not used");
   sw_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SCS_SRC_SW && rail_on_ff && !good_ff) |->
      slow_clk == int_osc_clk)
      else $error("no fallback");
   sw_railoff_a: assert property (@(posedge pclk) disable iff (!presetn)
      (src == SCS_SRC_SW && !rail_on_ff) |->
      slow_clk_enabled == !emul)
      else $error("rail off gating wrong");
   int_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!int_en) |->
      !int_osc_run)
      else $error("internal osc ran");
   ext_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ext_en) |->
      (src != SCS_SRC_XTAL && src != SCS_SRC_SE && src != SCS_SRC_SW))
      else $error("external not disabled");
   xtal_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ext_en) |->
      !crystal_osc_run)
      else $error("crystal ran while disabled");
   sw_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ext_en && xsel && sw_dis) |->
      src == SCS_SRC_SE)
      else $error("switch not disabled");
   rail_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      rail_up_s |=>
      rail_on_ff)
      else $error("rail on not seen");
   rail_down_a: assert property (@(posedge pclk) disable iff (!presetn)
      rail_down_s |=>
      !rail_on_ff)
      else $error("rail off not seen");
   good_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      good_up_s |=>
      good_ff)
      else $error("external clock good not seen");
   clk_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_wr_s |=>
      clk_en_ff == $past(pwdata[SCS_CLK_EN_W-1:0]))
      else $error("clock enable write lost");
   clk_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_clk) |->
      prdata[31:SCS_CLK_EN_W] == '0)
      else $error("clock enable reserved bits set");
   pin_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_pin) |->
      prdata[31:2] == 30'h0)
      else $error("pin domain reserved bits set");
   bgo_tri_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!pin_dom_ff[SCS_BIT_BGO_DOM] && !rail_on_ff) |->
      !bgo_pin_oe)
      else $error("battery pin not tristated");
   bgo_batt_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_dom_ff[SCS_BIT_BGO_DOM] |->
      (bgo_pin_oe && bgo_pin_out == battery_general_output))
      else $error("output pin not battery driven");
   bco_batt_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_dom_ff[SCS_BIT_BCO_DOM] |->
      (bco_pin_oe && bco_pin_out == battery_control_output))
      else $error("control pin not battery driven");
   bco_tri_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!pin_dom_ff[SCS_BIT_BCO_DOM] && !rail_on_ff) |->
      !bco_pin_oe)
      else $error("control pin not tristated");
   gpo_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!pin_dom_ff[SCS_BIT_BCO_DOM] && rail_on_ff) |->
      (bco_pin_oe && bco_pin_out == gpio_general_output))
      else $error("control pin not general driven");
   write_effect_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_wr_s |=>
      pin_dom_ff == $past(pwdata[1:0]))
      else $error("pin domain write lost");
endmodule : scs_top
`default_nettype wire

// [bench/tb_slow_clock_source_select.sv]
// Self-checking bench for the slow clock source select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_slow_clock_source_select;
   import scs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, boot = 0, rail = 0, good = 0, ic = 0, cc = 0, xo = 0;
   logic gpo = 0, bgo = 0, bco = 0, sclk, sen, irun, crun, refs, bgo_o, bgo_e, bco_o, bco_e;
   logic [2:0] src;
   int fails = 0, compares = 0, m_clk = 0, m_dom = 3;
   scs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .boot_exception(boot), .main_power_rail(rail),
      .ext_clock_good(good), .int_osc_clk(ic), .crystal_clk(cc), .crystal_output_pin(xo),
      .gpio_general_output(gpo), .battery_general_output(bgo),
      .battery_control_output(bco), .slow_clk(sclk), .slow_clk_enabled(sen),
      .int_osc_run(irun), .crystal_osc_run(crun), .ref_sel_switched(refs),
      .clk_source(src), .bgo_pin_out(bgo_o), .bgo_pin_oe(bgo_e), .bco_pin_out(bco_o),
      .bco_pin_oe(bco_e));
   always #10 pclk = ~pclk;
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task do_reset;
      @(posedge pclk);
      presetn <= 0;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      m_clk = 0;
      m_dom = 3;
      repeat (6) @(posedge pclk);
   endtask : do_reset
   // Outputs compared with a table-driven model; filters need up to 4 edges to settle
   task check_all;
      int s, ie, em, intc, ec, gt;
      repeat (6) @(posedge pclk);
      ie = m_clk[2];
      em = m_clk[3];
      s = !m_clk[1] ? (ie ? 1 : 0) : (!m_clk[0] ? 2 : ((!ie || m_clk[4]) ? 3 : 4));
      gt = rail || !em;
      intc = gt ? ic : 0;
      ec = s == 0 ? 0 : s == 1 ? intc : s == 2 ? cc : s == 3 ? xo : ((rail && good) ? xo : intc);
      `CHK("source", s, src)
      `CHK("slow_clk", ec, sclk)
      `CHK("clk_live", s == 0 ? 0 : (s == 1 || (s == 4 && !(rail && good))) ? gt : 1, sen)
      `CHK("int_run", ie && (rail || !em), irun)
      `CHK("xtal_run", m_clk[1] && !m_clk[0], crun)
      `CHK("ref_sel", m_clk[5], refs)
      `CHK("bgo_oe", m_dom[1] || rail, bgo_e)
      `CHK("bco_oe", m_dom[0] || rail, bco_e)
      if (m_dom[1] || rail) `CHK("bgo_out", m_dom[1] ? bgo : gpo, bgo_o)
      if (m_dom[0] || rail) `CHK("bco_out", m_dom[0] ? bco : gpo, bco_o)
      apb(0, SCS_OFF_CLK_EN, 0);
      `CHK("clk_en_rd", m_clk, rd)
      apb(0, SCS_OFF_PIN_DOM, 0);
      `CHK("pin_dom_rd", m_dom, rd)
      `CHK("no_err", 1'b0, err)
   endtask : check_all
   task end_of_test;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #(20 * 30000);
      fails++;
      end_of_test();
   end
   initial begin
      logic [31:0] w;
      void'($urandom(32'h697b));
      do_reset();
      check_all();
      for (int i = 0; i < 60; i++) begin
         w = $urandom;
         apb(1, SCS_OFF_CLK_EN, w);
         m_clk = w[5:0];
         w = $urandom;
         apb(1, SCS_OFF_PIN_DOM, w);
         m_dom = w[1:0];
         {rail, good, ic, cc, xo, gpo, bgo, bco} <= 8'($urandom);
         check_all();
         if (i == 30) begin
            do_reset();
            check_all();
         end
      end
      // Unmapped access answers with an error and reads zero
      apb(1, 8'h0c, 32'hffffffff);
      `CHK("unmap_wr_err", 1'b1, err)
      apb(0, 8'h0c, 0);
      `CHK("unmap_err", 1'b1, err)
      `CHK("unmap_rd", 32'h0, rd)
      // Boot exception forces 04h and overrides software writes
      boot <= 1;
      repeat (6) @(posedge pclk);
      apb(1, SCS_OFF_CLK_EN, 32'h3b);
      m_clk = 4;
      check_all();
      boot <= 0;
      repeat (6) @(posedge pclk);
      apb(1, SCS_OFF_CLK_EN, 32'h03);
      m_clk = 3;
      check_all();
      end_of_test();
   end
endmodule : tb_slow_clock_source_select
`default_nettype wire
